// ---- verilog/mss_pkg.sv ----
package mss_pkg;

  // tick and filter timing
  localparam int CLK_PERIOD_NS = 40;
  localparam int TICK_NS = 1000000;
  localparam int TICK_CYCLES_DEF = TICK_NS / CLK_PERIOD_NS;
  localparam int TICK_MS = 1;
  localparam int HALT_FILTER_MS = 100;
  // strictly longer than the filter time
  localparam logic [7:0] FILTER_TICKS = 8'(HALT_FILTER_MS / TICK_MS + 1);

  localparam logic [15:0] FULL_SCALE = 16'hFFFF;

  // register indices, byte address is four times the index
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_PANEL_REF = 4'h1;
  localparam logic [3:0] REG_INCH_REF = 4'h2;
  localparam logic [3:0] REG_ACCEL_TIME = 4'h3;
  localparam logic [3:0] REG_INCH_ACCEL_TIME = 4'h4;
  localparam logic [3:0] REG_DECEL_TIME = 4'h5;
  localparam logic [3:0] REG_HALT_RAMP_TIME = 4'h6;
  localparam logic [3:0] REG_STAGE_OFF_DELAY = 4'h7;
  localparam logic [3:0] REG_SPEED_OFFSET = 4'h8;
  localparam logic [3:0] REG_STATUS = 4'h9;
  localparam logic [3:0] REG_SPEED = 4'hA;
  localparam int CFG_WORDS = 9;

  // control register fields
  localparam int CTRL_LOCAL = 0;
  localparam int CTRL_COAST = 1;
  localparam int CTRL_QUICK_COAST = 2;
  localparam int CTRL_RAMP_FREEZE = 3;
  localparam int CTRL_OFFSET_EN = 4;
  localparam int CTRL_TRIP_RESET = 5;
  localparam logic [15:0] CTRL_MASK = 16'h001F;

  // values after reset, times in milliseconds
  localparam logic [15:0] CFG_RST [0:CFG_WORDS-1] = '{
    16'h0000, 16'h0000, 16'h1999, 16'h2710, 16'h03E8,
    16'h2710, 16'h2710, 16'h01F4, 16'h0000
  };

  typedef enum logic [2:0] {
    SQ_IDLE,
    SQ_RUN,
    SQ_INCH,
    SQ_DECEL,
    SQ_TRIM,
    SQ_DELAY
  } mss_state_t;

endpackage : mss_pkg

// ---- verilog/mss_sequencer.sv ----
// Chosen here: the register offsets and register access over APB.
`timescale 1ns/1ns
module mss_sequencer #(
  parameter int TICK_CYCLES = mss_pkg::TICK_CYCLES_DEF
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // remote inputs
  input wire logic [15:0] ain1Level,
  input wire logic [15:0] ain2Level,
  input wire logic dirSelect,
  input wire logic runForwardCmd,
  input wire logic runReverseCmd,
  input wire logic inchCmd,
  input wire logic haltRequestB,
  input wire logic quickHaltB,
  input wire logic freewheelHaltB,
  input wire logic powerStagePermit,
  input wire logic tripDetect,
  // panel keys
  input wire logic runKey,
  input wire logic haltKey,
  input wire logic inchKey,
  input wire logic rotationSenseKey,
  // drive outputs
  output logic [15:0] speedCommand,
  output logic reverseDir,
  output logic stageEnable,
  output logic runningFlag,
  output logic noFaultFlag
);
  import mss_pkg::*;

  function automatic logic [15:0] satAdd(input logic [15:0] a, input logic [15:0] b);
    logic [16:0] s;
    s = {1'b0, a} + {1'b0, b};
    return s[16] ? FULL_SCALE : s[15:0];
  endfunction : satAdd

  function automatic logic [15:0] rampTo(input logic [15:0] cur, input logic [15:0] tgt,
                                         input logic [15:0] step);
    logic [15:0] gap;
    gap = (cur > tgt) ? cur - tgt : tgt - cur;
    if (gap <= step) begin
      return tgt;
    end
    return (cur > tgt) ? cur - step : cur + step;
  endfunction : rampTo

  // state
  mss_state_t state_q, state_d;
  logic [15:0] cfg_q [0:CFG_WORDS-1];
  logic [15:0] prescale_q;
  logic [15:0] tmr_q;
  logic [15:0] speed_q, speed_d;
  logic [15:0] offset_q, offset_d;
  logic [15:0] speedCommand_q;
  logic [7:0] fwdCnt_q, revCnt_q, haltCnt_q;
  logic reverse_q, runLatched_q, runFromRev_q;
  logic tripped_q, stage_q, running_q, noFault_q;
  logic [31:0] prdata_q;
  logic pready_q, pslverr_q;

  // apb decode
  wire [3:0] regIdx = paddr[5:2];
  wire wordAligned = (paddr[1:0] == 2'b00) && (paddr[7:6] == 2'b00);
  wire cfgHit = wordAligned && (regIdx < 4'(CFG_WORDS));
  wire roHit = wordAligned && ((regIdx == REG_STATUS) || (regIdx == REG_SPEED));
  wire addrHit = cfgHit || roHit;
  wire apbSetup = psel && penable && !pready_q;
  wire apbDone = psel && penable && pready_q;
  wire cfgWrite = apbDone && pwrite && cfgHit;
  wire tripResetPulse = cfgWrite && (regIdx == REG_CTRL) && pwdata[CTRL_TRIP_RESET];

  // configuration fields
  wire [15:0] ctrlBits = cfg_q[REG_CTRL];
  wire localMode = ctrlBits[CTRL_LOCAL];
  wire coastCfg = ctrlBits[CTRL_COAST];
  wire quickCoastCfg = ctrlBits[CTRL_QUICK_COAST];
  wire rampFreeze = ctrlBits[CTRL_RAMP_FREEZE];
  wire offsetEn = ctrlBits[CTRL_OFFSET_EN];
  wire [15:0] decelTime = cfg_q[REG_DECEL_TIME];

  // ms tick for all ramps and timers
  wire tick = (prescale_q == 16'(TICK_CYCLES - 1));

  // references
  wire [15:0] remoteRef = satAdd(ain1Level, ain2Level);
  wire [15:0] runRef = localMode ? cfg_q[REG_PANEL_REF] : remoteRef;

  // remote run qualification
  wire fwdLong = (fwdCnt_q == FILTER_TICKS);
  wire revLong = (revCnt_q == FILTER_TICKS);
  wire haltLong = (haltCnt_q == FILTER_TICKS);
  wire bothRun = runForwardCmd && runReverseCmd;
  // halt request held low: level run, no latching
  wire remFwd = !bothRun && (haltRequestB ? fwdLong : runForwardCmd);
  wire remRev = !bothRun && !remFwd && (haltRequestB ? revLong : runReverseCmd);
  wire remRunReq = remFwd || remRev;
  wire locRunReq = runKey && !haltKey;
  wire runReq = localMode ? locRunReq : remRunReq;
  wire startRev = localMode ? rotationSenseKey : (dirSelect ^ remRev);
  wire inchReq = localMode ? inchKey : inchCmd;

  // hold conditions while running
  wire nonLatchHold = runFromRev_q ? runReverseCmd : runForwardCmd;
  // opposite command alone is not looked at while latched; both commands together still stop the run
  wire remHold = !bothRun && (runLatched_q ? !haltLong : nonLatchHold);
  wire runHold = localMode ? !haltKey : remHold;

  // halt sources
  wire coastNow = !freewheelHaltB || !powerStagePermit || tripDetect || tripped_q;
  wire quickNow = !quickHaltB;
  wire startInhibit = coastNow || quickNow;
  wire useHaltRamp = (decelTime == 16'h0000) || rampFreeze;
  wire tmrElapsed = (tmr_q >= decelTime);
  wire delayElapsed = (tmr_q >= cfg_q[REG_STAGE_OFF_DELAY]);

  // ramp time for the current state, full-scale change
  logic [15:0] rampTime;
  logic [15:0] target;
  always_comb begin
    rampTime = 16'h0000;
    target = 16'h0000;
    case (state_q)
      SQ_RUN: begin
        rampTime = cfg_q[REG_ACCEL_TIME];
        target = runRef;
      end
      SQ_INCH: begin
        rampTime = cfg_q[REG_INCH_ACCEL_TIME];
        target = cfg_q[REG_INCH_REF];
      end
      SQ_DECEL: begin
        rampTime = decelTime;
      end
      SQ_TRIM: begin
        rampTime = cfg_q[REG_HALT_RAMP_TIME];
      end
      default: begin
        rampTime = 16'h0000;
      end
    endcase
  end

  // ceiling division so a ramp never outlasts its time
  wire [16:0] stepWide = (17'(FULL_SCALE) + 17'(rampTime) - 17'd1) / 17'(rampTime);
  wire [15:0] rampStep = (rampTime == 16'h0000) ? FULL_SCALE : stepWide[15:0];

  // sequencer
  always_comb begin
    state_d = state_q;
    case (state_q)
      SQ_IDLE: begin
        // run wins over inch when both arrive together
        if (!startInhibit && runReq) begin
          state_d = SQ_RUN;
        end else if (!startInhibit && inchReq) begin
          state_d = SQ_INCH;
        end
      end
      SQ_RUN: begin
        if (quickNow) begin
          state_d = quickCoastCfg ? SQ_IDLE : SQ_TRIM;
        end else if (!runHold) begin
          state_d = coastCfg ? SQ_IDLE : (useHaltRamp ? SQ_TRIM : SQ_DECEL);
        end
      end
      SQ_INCH: begin
        if (quickNow) begin
          state_d = quickCoastCfg ? SQ_IDLE : SQ_TRIM;
        end else if (!inchReq) begin
          state_d = coastCfg ? SQ_IDLE : (useHaltRamp ? SQ_TRIM : SQ_DECEL);
        end
      end
      SQ_DECEL: begin
        if (quickNow) begin
          state_d = quickCoastCfg ? SQ_IDLE : SQ_TRIM;
        end else if (offsetEn && tmrElapsed) begin
          state_d = SQ_TRIM;
        end else if (!offsetEn && (speed_q == 16'h0000)) begin
          state_d = SQ_DELAY;
        end
      end
      SQ_TRIM: begin
        if (quickNow && quickCoastCfg) begin
          state_d = SQ_IDLE;
        end else if ((speed_q == 16'h0000) && (offset_q == 16'h0000)) begin
          state_d = SQ_DELAY;
        end
      end
      SQ_DELAY: begin
        if (quickNow && quickCoastCfg) begin
          state_d = SQ_IDLE;
        end else if (delayElapsed) begin
          state_d = SQ_IDLE;
        end
      end
      default: begin
        state_d = SQ_IDLE;
      end
    endcase
    // freewheel, trip and missing permit beat everything
    if (coastNow) begin
      state_d = SQ_IDLE;
    end
  end

  // ramp values
  wire stateChange = (state_d != state_q);
  always_comb begin
    speed_d = speed_q;
    offset_d = offset_q;
    case (state_q)
      SQ_RUN, SQ_INCH: begin
        offset_d = offsetEn ? cfg_q[REG_SPEED_OFFSET] : 16'h0000;
        if (tick) begin
          speed_d = rampTo(speed_q, target, rampStep);
        end
      end
      SQ_DECEL: begin
        if (tick) begin
          speed_d = rampTo(speed_q, 16'h0000, rampStep);
        end
      end
      SQ_TRIM: begin
        if (tick) begin
          speed_d = rampTo(speed_q, 16'h0000, rampStep);
          offset_d = rampTo(offset_q, 16'h0000, rampStep);
        end
      end
      default: begin
        speed_d = 16'h0000;
        offset_d = 16'h0000;
      end
    endcase
    if (state_d == SQ_IDLE) begin
      speed_d = 16'h0000;
      offset_d = 16'h0000;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      prescale_q <= 16'h0000;
    end else begin
      prescale_q <= tick ? 16'h0000 : prescale_q + 16'h0001;
    end
  end

  // input filters saturate one tick past the filter time
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      fwdCnt_q <= 8'h00;
      revCnt_q <= 8'h00;
      haltCnt_q <= 8'h00;
    end else begin
      fwdCnt_q <= !runForwardCmd ? 8'h00 : fwdCnt_q + 8'(tick && !fwdLong);
      revCnt_q <= !runReverseCmd ? 8'h00 : revCnt_q + 8'(tick && !revLong);
      haltCnt_q <= haltRequestB ? 8'h00 : haltCnt_q + 8'(tick && !haltLong);
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= SQ_IDLE;
      tmr_q <= 16'h0000;
      speed_q <= 16'h0000;
      offset_q <= 16'h0000;
    end else begin
      state_q <= state_d;
      tmr_q <= stateChange ? 16'h0000 : tmr_q + 16'(tick && (tmr_q != 16'hFFFF));
      speed_q <= speed_d;
      offset_q <= offset_d;
    end
  end

  // start-time choices stay fixed for the whole run
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      reverse_q <= 1'b0;
      runLatched_q <= 1'b0;
      runFromRev_q <= 1'b0;
    end else if ((state_q == SQ_IDLE) && (state_d != SQ_IDLE)) begin
      reverse_q <= startRev;
      runLatched_q <= haltRequestB && !localMode;
      runFromRev_q <= remRev;
    end
  end

  // a new trip in the reset cycle keeps the drive tripped
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      tripped_q <= 1'b0;
    end else begin
      tripped_q <= tripDetect || (tripped_q && !tripResetPulse);
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      stage_q <= 1'b0;
      running_q <= 1'b0;
      noFault_q <= 1'b1;
      speedCommand_q <= 16'h0000;
    end else begin
      stage_q <= (state_d != SQ_IDLE) && powerStagePermit;
      running_q <= (state_d != SQ_IDLE);
      noFault_q <= !(tripDetect || (tripped_q && !tripResetPulse));
      speedCommand_q <= satAdd(speed_d, offset_d);
    end
  end

  // configuration words
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < CFG_WORDS; i++) begin
        cfg_q[i] <= CFG_RST[i];
      end
    end else if (cfgWrite) begin
      cfg_q[regIdx] <= (regIdx == REG_CTRL) ? (pwdata[15:0] & CTRL_MASK) : pwdata[15:0];
    end
  end

  // read mux
  wire [7:0] statusByte = {tripped_q, stage_q, running_q, reverse_q, runLatched_q, 3'(state_q)};
  wire [31:0] cfgRead = cfgHit ? {16'h0000, cfg_q[regIdx[3:0]]} : 32'h0000_0000;
  wire [31:0] readMux = (regIdx == REG_STATUS && roHit) ? {24'h00_0000, statusByte} :
                        (regIdx == REG_SPEED && roHit) ? {offset_q, speedCommand_q} : cfgRead;

  // one wait state keeps every bus output registered
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end else begin
      pready_q <= apbSetup;
      pslverr_q <= apbSetup && !addrHit;
      prdata_q <= (apbSetup && !pwrite) ? readMux : 32'h0000_0000;
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign speedCommand = speedCommand_q;
  assign reverseDir = reverse_q;
  assign stageEnable = stage_q;
  assign runningFlag = running_q;
  assign noFaultFlag = noFault_q;

endmodule : mss_sequencer

// ---- dv/mss_chk.sv ----
`timescale 1ns/1ns
module mss_chk (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  // commands
  input wire logic runForwardCmd,
  input wire logic runReverseCmd,
  input wire logic inchCmd,
  input wire logic haltRequestB,
  input wire logic quickHaltB,
  input wire logic freewheelHaltB,
  input wire logic powerStagePermit,
  input wire logic tripDetect,
  // outputs
  input wire logic [15:0] speedCommand,
  input wire logic stageEnable,
  input wire logic runningFlag,
  input wire logic noFaultFlag
);
  // shadow of the control word, so halt style is known here
  logic [4:0] ctrl_q;
  logic ctrlWr;
  logic idleGo;
  assign ctrlWr = psel && penable && pready && pwrite && paddr == 8'h00;
  assign idleGo = quickHaltB && freewheelHaltB && powerStagePermit && !tripDetect;
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) ctrl_q <= 5'h00;
    else if (ctrlWr) ctrl_q <= pwdata[4:0];
  end
  // latched at start as the design does; a latched run ignores a short halt
  logic runLatch_q;
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) runLatch_q <= 1'b0;
    else if (!runningFlag) runLatch_q <= haltRequestB && !ctrl_q[0];
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  a_trip_no_fault_flag: assert property (tripDetect |=> !noFaultFlag)
    else $error("no fault flag still set under trip");
  a_trip_stage: assert property (tripDetect |=> !stageEnable && !runningFlag)
    else $error("stage or running left on under trip");
  a_freewheel_off: assert property (!freewheelHaltB |=> !stageEnable)
    else $error("stage on during freewheel halt");
  a_permit_off: assert property (!powerStagePermit |=> !stageEnable)
    else $error("stage on without permit");
  a_stage_running: assert property (stageEnable |-> runningFlag)
    else $error("stage on while not running");
  a_stop_end: assert property ($fell(stageEnable) |-> !runningFlag)
    else $error("running flag outlives stage");
  a_coast_stop: assert property (ctrl_q == 5'h06 && runningFlag && !haltRequestB
    && !runLatch_q && !runForwardCmd && !runReverseCmd && !inchCmd
    |=> !stageEnable && speedCommand == 16'h0000)
    else $error("coast halt did not zero speed and stage");
  a_both_stop: assert property (ctrl_q == 5'h06 && runForwardCmd && runReverseCmd
    && !inchCmd |-> ##[1:3] !runningFlag)
    else $error("both run commands did not stop");
  a_two_wire: assert property (!ctrl_q[0] && !haltRequestB && runForwardCmd
    && !runReverseCmd && !inchCmd && !runningFlag && idleGo && noFaultFlag
    |=> runningFlag && stageEnable)
    else $error("held run command did not start");
  a_quick_coast: assert property (ctrl_q[2] && !quickHaltB |=> !stageEnable)
    else $error("quick coast left stage on");
  cover property ($rose(runningFlag));
  cover property ($fell(noFaultFlag));
  cover property (ctrlWr);
endmodule : mss_chk

// ---- dv/mss_sw_model.sv ----
`timescale 1ns/1ns
module mss_sw_model (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // wanted positions: fwd rev inch haltB runKey haltKey inchKey dirKey
  input wire logic [7:0] swWant,
  // contact levels
  output logic [7:0] swLevel
);
  // contacts settle one clock after the operator acts; halt held by caller
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) swLevel <= 8'h00;
    else swLevel <= swWant;
  end
endmodule : mss_sw_model

// ---- dv/tb_top.sv ----
`timescale 1ns/1ns
module tb_top;
  import mss_pkg::*;
  logic core_clk = 1'b0;
  logic rst_b = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, er;
  logic [15:0] ain1Level = 16'h0000;
  logic [15:0] ain2Level = 16'h0000;
  logic dirSelect = 1'b0;
  logic quickHaltB = 1'b1;
  logic freewheelHaltB = 1'b1;
  logic powerStagePermit = 1'b1;
  logic tripDetect = 1'b0;
  logic [7:0] sw = 8'h00;
  logic [7:0] swLevel;
  logic [15:0] speedCommand;
  logic reverseDir, stageEnable, runningFlag, noFaultFlag;
  logic [15:0] rnd = 16'h004D;
  int nErrors = 0;
  int numChecks = 0;
  always #20 core_clk = ~core_clk;
  mss_sw_model sw_u (.core_clk, .rst_b, .swWant(sw), .swLevel);
  mss_sequencer #(.TICK_CYCLES(10)) dut_u (.*, .runForwardCmd(swLevel[0]),
    .runReverseCmd(swLevel[1]), .inchCmd(swLevel[2]), .haltRequestB(swLevel[3]),
    .runKey(swLevel[4]), .haltKey(swLevel[5]), .inchKey(swLevel[6]),
    .rotationSenseKey(swLevel[7]));
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    numChecks++;
    if (g !== e) begin
      nErrors++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask : cyc
  // request held until pready is seen at an edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    @(posedge core_clk);
    while (!pready) @(posedge core_clk);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  endtask : apb
  task automatic report_and_stop;
    $display("checks %0d errors %0d", numChecks, nErrors);
    if (nErrors == 0 && numChecks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : report_and_stop
  initial begin
    #800000;
    nErrors++;
    report_and_stop();
  end
  initial begin
    cyc(20);
    rst_b <= 1'b1;
    cyc(1);
    for (int i = 0; i < CFG_WORDS; i++) begin
      apb(1'b0, 8'(i * 4), 32'h0);
      chk("cfg reset", {16'h0000, CFG_RST[i]}, rd);
    end
    apb(1'b0, 8'h2C, 32'h0);
    chk("unmapped", 32'h1, {31'h0, er});
    apb(1'b1, 8'h00, 32'h6);
    apb(1'b1, 8'h0C, 32'h0);
    apb(1'b1, 8'h10, 32'h0);
    for (int k = 0; k < 4; k++) begin
      rnd = lfsr(rnd);
      ain1Level <= {1'b0, rnd[14:0]};
      dirSelect <= rnd[15];
      sw <= rnd[0] ? 8'h02 : 8'h01;
      rnd = lfsr(rnd);
      ain2Level <= {1'b0, rnd[14:0]};
      cyc(14);
      chk("speed", 16'(ain1Level + ain2Level), speedCommand);
      chk("dir", dirSelect ^ swLevel[1], reverseDir);
      sw <= 8'h00;
      cyc(3);
      chk("stage", 1'b0, stageEnable);
    end
    sw <= 8'h01;
    cyc(4);
    sw <= 8'h03;
    cyc(5);
    chk("both run", 1'b0, runningFlag);
    sw <= 8'h04;
    cyc(4);
    sw <= 8'h05;
    cyc(14);
    chk("inch speed", 16'h1999, speedCommand);
    sw <= 8'h00;
    cyc(3);
    chk("inch stop", 1'b0, runningFlag);
    sw <= 8'h09;
    cyc(1100);
    sw <= 8'h08;
    cyc(20);
    chk("latched", 1'b1, runningFlag);
    sw <= 8'h0A;
    cyc(1100);
    chk("opposite", dirSelect, reverseDir);
    sw <= 8'h00;
    cyc(1100);
    sw <= 8'h08;
    cyc(5);
    chk("logic stop", 1'b0, runningFlag);
    for (int k = 0; k < 3; k++) begin
      sw <= 8'h01;
      cyc(4);
      quickHaltB <= (k != 0);
      freewheelHaltB <= (k != 1);
      powerStagePermit <= (k != 2);
      cyc(3);
      chk("halt stage", 1'b0, stageEnable);
      {quickHaltB, freewheelHaltB, powerStagePermit} <= 3'h7;
      sw <= 8'h00;
      cyc(3);
    end
    sw <= 8'h01;
    cyc(4);
    tripDetect <= 1'b1;
    cyc(3);
    chk("no fault", 1'b0, noFaultFlag);
    tripDetect <= 1'b0;
    cyc(3);
    chk("trip stage", 1'b0, stageEnable);
    apb(1'b1, 8'h00, 32'h26);
    cyc(2);
    chk("trip reset", 1'b1, noFaultFlag);
    sw <= 8'h00;
    // ramped halt, then zero decel falls back to the halt ramp
    apb(1'b1, 8'h18, 32'h5);
    apb(1'b1, 8'h1C, 32'h3);
    for (int j = 0; j < 2; j++) begin
      apb(1'b1, 8'h00, 32'h0);
      apb(1'b1, 8'h14, j ? 32'h0 : 32'h5);
      ain1Level <= 16'h7FFF;
      ain2Level <= 16'h7FFF;
      sw <= 8'h01;
      cyc(14);
      sw <= 8'h00;
      cyc(25);
      chk("ramping", 1'b1, speedCommand != 16'h0);
      cyc(45);
      chk("ramp zero", 16'h0, speedCommand);
      chk("delay stage", 1'b1, stageEnable);
      cyc(60);
      chk("stopped", 1'b0, runningFlag);
    end
    apb(1'b1, 8'h00, 32'h7);
    apb(1'b1, 8'h04, 32'h1234);
    sw <= 8'h10;
    cyc(4);
    sw <= 8'h00;
    cyc(14);
    chk("key latch", 16'h1234, speedCommand);
    sw <= 8'h20;
    cyc(4);
    chk("halt key", 1'b0, runningFlag);
    sw <= 8'h40;
    cyc(14);
    chk("inch key", 16'h1999, speedCommand);
    sw <= 8'h00;
    cyc(3);
    chk("inch key off", 1'b0, runningFlag);
    report_and_stop();
  end
endmodule : tb_top
bind mss_sequencer mss_chk chk_u (.*);
